// ===== rtl/dps_supervisor.sv
module dps_supervisor
	import dps_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter bit CLASS_380 = 1'b0
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// measurements from sensing and pid logic
	input wire dps_meas_t meas_i,
	// protection actions
	output dps_prot_t prot_o
);

	localparam int DIV_W = $clog2(TICK_CYCLES + 1);

	// ---------------------------------------------------------------
	// tick divider
	// ---------------------------------------------------------------
	logic [DIV_W-1:0] div_r;
	logic tick;

	assign tick = (div_r == DIV_W'(TICK_CYCLES - 1));

	// free running, one pulse every 0.1 s
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			div_r <= '0;
		else if (tick)
			div_r <= '0;
		else
			div_r <= div_r + DIV_W'(1);
	end

	// ---------------------------------------------------------------
	// wishbone slave
	// ---------------------------------------------------------------
	logic [31:0] cfg_r [CFG_N];
	logic ack_r;
	logic [31:0] rdata_r;
	logic req;
	logic [5:0] idx;
	logic cfg_hit;
	logic stat_hit;
	logic [31:0] wmerge;
	logic [31:0] stat;
	logic loss_trip_r;
	logic imb_fault_r;
	logic [31:0] w1c;
	logic wr_ack;

	assign req = wb_cyc_i & wb_stb_i & ~ack_r;
	// writes commit on the edge where the master sees ack, not before
	assign wr_ack = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	assign idx = wb_adr_i[7:2];
	assign cfg_hit = (idx < 6'(CFG_N));
	assign stat_hit = (wb_adr_i == ADR_STAT);
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// byte lanes merged over the addressed word
	always_comb
	begin
		wmerge = cfg_hit ? cfg_r[idx[3:0]] : '0;
		for (int b = 0; b < 4; b++)
		begin
			if (wb_sel_i[b])
				wmerge[8*b +: 8] = wb_dat_i[8*b +: 8];
		end
	end

	// clear mask for the sticky status bits
	always_comb
	begin
		w1c = '0;
		if (wr_ack && stat_hit)
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (wb_sel_i[b])
					w1c[8*b +: 8] = wb_dat_i[8*b +: 8] & STAT_W1C[8*b +: 8];
			end
		end
	end

	// ack one cycle after the request; unmapped addresses still answer
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= req;
	end

	// reads return zero outside the map
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= '0;
		else if (req && !wb_we_i)
		begin
			if (cfg_hit)
				rdata_r <= cfg_r[idx[3:0]];
			else if (stat_hit)
				rdata_r <= stat;
			else
				rdata_r <= '0;
		end
	end

	// settings, defaults follow the voltage class
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int k = 0; k < CFG_N; k++)
				cfg_r[k] <= CLASS_380 ? RST_380[k] : RST_220[k];
		end
		else if (wr_ack && cfg_hit)
			cfg_r[idx[3:0]] <= wmerge & CFG_MASK[idx[3:0]];
	end

	// ---------------------------------------------------------------
	// setting fields
	// ---------------------------------------------------------------
	logic [3:0] dig_unit, dig_tens, dig_thou;
	logic [9:0] loss_thr;
	logic [TMR_W-1:0] loss_time;
	logic [7:0] pre_pct, pre_dly, mot_coef;
	logic [10:0] imb_coef;
	logic [13:0] dip_coef;
	logic [9:0] dip_v, ov_lvl, uv_lvl;
	logic [7:0] lim_pct, acc_coef, cst_coef, dec_fac;
	logic [7:0] osc_coef;
	logic [3:0] amp_coef;
	logic jog_pri;
	logic [2:0] pbp_dig;
	logic [11:0] band_lo, band_hi;

	assign dig_unit = cfg_r[0][F_DIG_UNIT +: 4];
	assign dig_tens = cfg_r[0][F_DIG_TENS +: 4];
	assign dig_thou = cfg_r[0][F_DIG_THOU +: 4];
	assign loss_thr = cfg_r[1][F_LO +: 10];
	assign loss_time = cfg_r[1][F_HI +: TMR_W];
	assign pre_pct = cfg_r[2][F_LO +: 8];
	assign pre_dly = cfg_r[2][F_B1 +: 8];
	assign mot_coef = cfg_r[2][F_B2 +: 8];
	assign imb_coef = cfg_r[3][F_LO +: 11];
	assign dip_coef = cfg_r[4][F_LO +: 14];
	assign dip_v = cfg_r[4][F_HI +: 10];
	assign ov_lvl = cfg_r[5][F_LO +: 10];
	assign uv_lvl = cfg_r[5][F_HI +: 10];
	assign lim_pct = cfg_r[6][F_LO +: 8];
	assign acc_coef = cfg_r[6][F_B1 +: 8];
	assign cst_coef = cfg_r[6][F_B2 +: 8];
	assign dec_fac = cfg_r[6][F_B3 +: 8];
	assign osc_coef = cfg_r[7][F_LO +: 8];
	assign amp_coef = cfg_r[7][F_AMP +: 4];
	assign jog_pri = cfg_r[7][F_JOG];
	assign pbp_dig = cfg_r[7][F_PBP +: 3];
	assign band_lo = cfg_r[8][F_LO +: 12];
	assign band_hi = cfg_r[8][F_HI +: 12];

	// ---------------------------------------------------------------
	// comparisons
	// ---------------------------------------------------------------
	logic [25:0] fb_scl, sp_scl;
	logic [15:0] pre_lvl, lim_lvl;
	logic [15:0] imax, imin;
	logic [27:0] imax_scl, imin_scl;
	logic loss_cond, pre_cond, imb_cond;

	// threshold is in 0.1 % of setpoint: fb * 1000 < thr * sp
	assign fb_scl = 26'(meas_i.fb) * PERMILLE;
	assign sp_scl = 26'(loss_thr) * 26'(meas_i.sp);
	assign loss_cond = (dig_tens == DIGIT_ON) && (loss_thr != '0)
		&& (fb_scl < sp_scl);

	assign pre_lvl = 16'(pre_pct) * PCT_TO_TENTH;
	assign pre_cond = (meas_i.i_out > pre_lvl);

	// largest and smallest phase current
	always_comb
	begin
		imax = meas_i.i_a;
		imin = meas_i.i_a;
		if (meas_i.i_b > imax)
			imax = meas_i.i_b;
		if (meas_i.i_c > imax)
			imax = meas_i.i_c;
		if (meas_i.i_b < imin)
			imin = meas_i.i_b;
		if (meas_i.i_c < imin)
			imin = meas_i.i_c;
	end

	// coefficient is in hundredths; a dead phase with others live
	// counts as unbounded ratio
	assign imax_scl = 28'(imax) * RATIO_SCALE;
	assign imin_scl = 28'(imb_coef) * 28'(imin);
	assign imb_cond = (imb_coef != '0) && (imax_scl > imin_scl);

	// ---------------------------------------------------------------
	// qualification timers
	// ---------------------------------------------------------------
	logic [2:0] tmr_cond;
	logic [2:0][TMR_W-1:0] tmr_lim;
	logic [2:0] tmr_qual;

	assign tmr_cond = {imb_cond, pre_cond, loss_cond};
	assign tmr_lim[0] = loss_time;
	assign tmr_lim[1] = TMR_W'(pre_dly);
	assign tmr_lim[2] = TMR_W'(IMB_TICKS + 1);

	generate
		for (genvar g = 0; g < 3; g++)
		begin : g_tmr
			logic [TMR_W-1:0] cnt_r;

			// counts whole ticks, so the first one may be short by
			// up to one tick; saturates instead of wrapping
			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
					cnt_r <= '0;
				else if (!tmr_cond[g])
					cnt_r <= '0;
				else if (tick && (cnt_r != '1))
					cnt_r <= cnt_r + TMR_W'(1);
			end

			assign tmr_qual[g] = tmr_cond[g] && (cnt_r >= tmr_lim[g]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// sticky faults
	// ---------------------------------------------------------------
	// coast-stop trip latches; set wins over clear
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			loss_trip_r <= 1'b0;
		else if (tmr_qual[0])
			loss_trip_r <= 1'b1;
		else if (w1c[S_LOSS])
			loss_trip_r <= 1'b0;
	end

	// imbalance fault latches; set wins over clear
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			imb_fault_r <= 1'b0;
		else if (tmr_qual[2])
			imb_fault_r <= 1'b1;
		else if (w1c[S_IMB])
			imb_fault_r <= 1'b0;
	end

	// ---------------------------------------------------------------
	// bus voltage, current limit, oscillation, jog
	// ---------------------------------------------------------------
	dps_prot_t prot_nxt;
	dps_prot_t prot_r;
	logic band_ok;
	logic running;

	assign lim_lvl = 16'(lim_pct) * PCT_TO_TENTH;
	assign running = (meas_i.run != RUN_IDLE);
	// band must be ordered and under the maximum frequency
	assign band_ok = (band_lo <= band_hi) && (band_hi <= meas_i.fmax);

	always_comb
	begin
		prot_nxt = '0;
		prot_nxt.loss_trip = loss_trip_r;
		prot_nxt.prealarm = tmr_qual[1];
		prot_nxt.output_imbalance_fault = imb_fault_r;
		prot_nxt.dip_active = (dip_coef != '0) && (meas_i.vbus < dip_v);
		prot_nxt.undervolt = (meas_i.vbus < uv_lvl);
		prot_nxt.ov_stall = (meas_i.vbus >= ov_lvl);
		prot_nxt.decel_vlim_act = (dec_fac != '0)
			&& (meas_i.run == RUN_DEC) && (meas_i.vbus >= ov_lvl);
		prot_nxt.decel_vlim_factor = dec_fac;
		prot_nxt.climit_active = (meas_i.i_out >= lim_lvl);
		case (meas_i.run)
			RUN_ACC: prot_nxt.pbp_limit_en = pbp_dig[0];
			RUN_DEC: prot_nxt.pbp_limit_en = pbp_dig[1];
			RUN_CONST: prot_nxt.pbp_limit_en = pbp_dig[2];
			default: prot_nxt.pbp_limit_en = 1'b0;
		endcase
		if ((meas_i.run == RUN_ACC) && prot_nxt.climit_active)
			prot_nxt.acc_supp_gain = acc_coef;
		if ((meas_i.run == RUN_CONST) && prot_nxt.climit_active)
			prot_nxt.const_supp_gain = cst_coef;
		prot_nxt.osc_active = (dig_thou == DIGIT_ON) && band_ok
			&& (meas_i.freq >= band_lo) && (meas_i.freq <= band_hi);
		prot_nxt.pwm_five_seg = prot_nxt.osc_active;
		if (prot_nxt.osc_active)
		begin
			prot_nxt.osc_coef = osc_coef;
			prot_nxt.amp_coef = amp_coef;
		end
		prot_nxt.jog_grant = jog_pri && running && meas_i.jog_req;
		// motor overload level against inverter rating
		prot_nxt.motor_ovl_en = (dig_unit == DIGIT_ON);
		prot_nxt.motor_ovl_lvl = 16'(mot_coef) * PCT_TO_TENTH;
	end

	// outputs come from flip-flops, one cycle behind the inputs
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			prot_r <= '0;
		else
			prot_r <= prot_nxt;
	end

	assign prot_o = prot_r;

	// ---------------------------------------------------------------
	// status word
	// ---------------------------------------------------------------
	always_comb
	begin
		stat = '0;
		stat[S_LOSS] = loss_trip_r;
		stat[S_IMB] = imb_fault_r;
		stat[S_PRE] = prot_r.prealarm;
		stat[S_DIP] = prot_r.dip_active;
		stat[S_UV] = prot_r.undervolt;
		stat[S_OV] = prot_r.ov_stall;
		stat[S_CLIM] = prot_r.climit_active;
		stat[S_OSC] = prot_r.osc_active;
	end

endmodule

// ===== shared/dps_pkg.sv
package dps_pkg;

	// ---------------------------------------------------------------
	// time base
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 250_000_000;
	localparam int TICK_MS = 100; // one supervision tick is 0.1 s
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int IMB_TIME_S = 6; // imbalance must last longer than this
	localparam int IMB_TICKS = IMB_TIME_S * 1000 / TICK_MS;
	localparam int TMR_W = 14;
	localparam int MS_PER_S = 1000;

	// ---------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam int CFG_N = 9;
	localparam logic [7:0] ADR_PROT = 8'h00;
	localparam logic [7:0] ADR_LOSS = 8'h04;
	localparam logic [7:0] ADR_OVLD = 8'h08;
	localparam logic [7:0] ADR_IMB = 8'h0C;
	localparam logic [7:0] ADR_DIP = 8'h10;
	localparam logic [7:0] ADR_VLIM = 8'h14;
	localparam logic [7:0] ADR_CLIM = 8'h18;
	localparam logic [7:0] ADR_OSC = 8'h1C;
	localparam logic [7:0] ADR_BAND = 8'h20;
	localparam logic [7:0] ADR_STAT = 8'h24;

	// field positions
	localparam int F_DIG_UNIT = 0;
	localparam int F_DIG_TENS = 4;
	localparam int F_DIG_HUND = 8;
	localparam int F_DIG_THOU = 12;
	localparam int F_LO = 0; // low field of a two-field word
	localparam int F_HI = 16; // high field of a two-field word
	localparam int F_B1 = 8;
	localparam int F_B2 = 16;
	localparam int F_B3 = 24;
	localparam int F_AMP = 8;
	localparam int F_JOG = 12;
	localparam int F_PBP = 13;

	// status bits
	localparam int S_LOSS = 0;
	localparam int S_IMB = 1;
	localparam int S_PRE = 2;
	localparam int S_DIP = 3;
	localparam int S_UV = 4;
	localparam int S_OV = 5;
	localparam int S_CLIM = 6;
	localparam int S_OSC = 7;
	localparam logic [31:0] STAT_W1C = 32'h0000_0003;

	// reset values, 220 V class and 380 V class
	localparam logic [31:0] RST_220 [CFG_N] = '{32'h0000_0001,
		32'h0064_0000, 32'h0064_3278, 32'h0000_00C8, 32'h00FA_0000,
		32'h00B4_0177, 32'h0100_0AA0, 32'h0000_651E, 32'h01C2_0032};
	localparam logic [31:0] RST_380 [CFG_N] = '{32'h0000_0001,
		32'h0064_0000, 32'h0064_3278, 32'h0000_00C8, 32'h01C2_0000,
		32'h0168_02BC, 32'h0100_0AA0, 32'h0000_651E, 32'h01C2_0032};
	localparam logic [31:0] CFG_MASK [CFG_N] = '{32'h0000_FFFF,
		32'h3FFF_03FF, 32'h00FF_FFFF, 32'h0000_07FF, 32'h03FF_3FFF,
		32'h03FF_03FF, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0FFF_0FFF};

	// scale factors
	localparam logic [25:0] PERMILLE = 26'h00003E8;
	localparam logic [15:0] PCT_TO_TENTH = 16'h000A;
	localparam logic [27:0] RATIO_SCALE = 28'h0000064;
	localparam logic [3:0] DIGIT_ON = 4'h1;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {RUN_IDLE, RUN_ACC, RUN_DEC, RUN_CONST} dps_run_t;

	typedef struct packed {
		logic [15:0] fb; // pid feedback
		logic [15:0] sp; // pid setpoint, same scale
		logic [15:0] i_out; // output current, 0.1 % of rated
		logic [15:0] i_a;
		logic [15:0] i_b;
		logic [15:0] i_c;
		logic [9:0] vbus; // dc bus, volts
		logic [11:0] freq; // output frequency, 0.1 Hz
		logic [11:0] fmax; // maximum frequency, 0.1 Hz
		dps_run_t run;
		logic jog_req;
	} dps_meas_t;

	typedef struct packed {
		logic loss_trip;
		logic prealarm;
		logic output_imbalance_fault;
		logic dip_active;
		logic undervolt;
		logic ov_stall;
		logic decel_vlim_act;
		logic [7:0] decel_vlim_factor;
		logic climit_active;
		logic pbp_limit_en;
		logic [7:0] acc_supp_gain;
		logic [7:0] const_supp_gain;
		logic osc_active;
		logic pwm_five_seg;
		logic [7:0] osc_coef;
		logic [3:0] amp_coef;
		logic jog_grant;
		logic motor_ovl_en;
		logic [15:0] motor_ovl_lvl; // 0.1 % of inverter rated current
	} dps_prot_t;

endpackage

// ===== verif/dps_monitor.sv
module dps_monitor
	import dps_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// bus handshake
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// measurements and actions
	input wire dps_meas_t meas_i,
	input wire dps_prot_t prot_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ---------------------------------------------------------------
	// bus handshake
	// ---------------------------------------------------------------
	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("ack wider than one cycle");
	property p_ack_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_req: assert property (p_ack_req)
		else $error("request not acknowledged");

	// ---------------------------------------------------------------
	// action outputs against the run phase one cycle back
	// ---------------------------------------------------------------
	property p_jog;
		prot_o.jog_grant |-> $past(meas_i.jog_req)
			&& $past(meas_i.run) != RUN_IDLE;
	endproperty
	a_jog: assert property (p_jog)
		else $error("jog granted without running request");
	property p_pbp;
		prot_o.pbp_limit_en |-> $past(meas_i.run) != RUN_IDLE;
	endproperty
	a_pbp: assert property (p_pbp)
		else $error("pulse limit enabled while idle");
	property p_acc;
		prot_o.acc_supp_gain != 8'h00 |-> prot_o.climit_active
			&& $past(meas_i.run) == RUN_ACC;
	endproperty
	a_acc: assert property (p_acc)
		else $error("accel gain outside accel limiting");
	property p_cst;
		prot_o.const_supp_gain != 8'h00 |-> prot_o.climit_active
			&& $past(meas_i.run) == RUN_CONST;
	endproperty
	a_cst: assert property (p_cst)
		else $error("constant gain outside constant limiting");
	property p_dvl;
		prot_o.decel_vlim_act |-> prot_o.decel_vlim_factor != 8'h00
			&& prot_o.ov_stall && $past(meas_i.run) == RUN_DEC;
	endproperty
	a_dvl: assert property (p_dvl)
		else $error("decel voltage limit without cause");

	// ---------------------------------------------------------------
	// oscillation suppression
	// ---------------------------------------------------------------
	property p_five;
		prot_o.pwm_five_seg == prot_o.osc_active;
	endproperty
	a_five: assert property (p_five)
		else $error("five segment pwm not tied to suppression");
	property p_band;
		prot_o.osc_active |-> $past(meas_i.freq <= meas_i.fmax);
	endproperty
	a_band: assert property (p_band)
		else $error("suppression above maximum frequency");
	property p_oscz;
		!prot_o.osc_active |-> prot_o.osc_coef == 8'h00
			&& prot_o.amp_coef == 4'h0;
	endproperty
	a_oscz: assert property (p_oscz)
		else $error("coefficients shown while inactive");

	// main scenarios reached
	c_osc: cover property (prot_o.osc_active);
	c_loss: cover property (prot_o.loss_trip);
	c_imb: cover property (prot_o.output_imbalance_fault);
endmodule

bind dps_supervisor dps_monitor u_mon (.clk_sys(clk_sys),
	.rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .meas_i(meas_i), .prot_o(prot_o));

// ===== verif/dps_sense_model.sv
module dps_sense_model
	import dps_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// operating point asked for
	input wire dps_meas_t want_i,
	// sampled measurements
	output dps_meas_t meas_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// one sample of latency, as an adc frame would add
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			meas_o <= '0;
		else
			meas_o <= want_i;
	end
endmodule

// ===== verif/drive_protection_supervisor_bench.sv
module drive_protection_supervisor_bench;
	import dps_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack;
	dps_meas_t want;
	dps_meas_t meas;
	dps_prot_t prot;
	int bad_count = 0;
	int total_checks = 0;

	// ---------------------------------------------------------------
	// clock, partner and design
	// ---------------------------------------------------------------
	always #2 clk_sys = ~clk_sys;
	dps_sense_model sense (.clk_sys(clk_sys), .rst_n(rst_n),
		.want_i(want), .meas_o(meas));
	dps_supervisor #(.TICK_CYCLES(TK)) dut (.clk_sys(clk_sys),
		.rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .meas_i(meas),
		.prot_o(prot));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// whole classic cycle; waits on ack, never on a cycle count
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk_sys);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic vb(input logic [9:0] v);
		want.vbus <= v;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// hang guard, about six times the expected run
	initial
	begin
		#40000;
		bad_count++;
		results();
	end

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial
	begin
		want = '0;
		want.sp = 16'h03E8;
		want.fb = 16'h03E8;
		want.fmax = 12'h1F4;
		want.vbus = 10'h12C;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		// settings come up at their defaults
		for (int i = 0; i < CFG_N; i++)
		begin
			bus(1'b0, 8'(4 * i), 32'h0);
			chk(q, RST_220[i]);
		end
		bus(1'b0, 8'h28, 32'h0);
		chk(q, 32'h0);
		chk(prot.motor_ovl_lvl, 32'h3E8);
		chk(prot.motor_ovl_en, 32'h1);
		// loss at 50.0 % of setpoint after 3 ticks
		bus(1'b1, ADR_PROT, 32'h0000_0011);
		bus(1'b1, ADR_LOSS, 32'h0003_01F4);
		want.fb <= 16'h0190;
		repeat (18) @(posedge clk_sys);
		chk(prot.loss_trip, 32'h0);
		want.fb <= 16'h03E8;
		repeat (2) @(posedge clk_sys);
		want.fb <= 16'h0190;
		repeat (18) @(posedge clk_sys);
		chk(prot.loss_trip, 32'h0);
		repeat (20) @(posedge clk_sys);
		chk(prot.loss_trip, 32'h1);
		want.fb <= 16'h03E8;
		bus(1'b1, ADR_STAT, 32'h1);
		// tens digit 0 must keep the low feedback from tripping
		bus(1'b1, ADR_PROT, 32'h0000_0001);
		want.fb <= 16'h0190;
		repeat (60) @(posedge clk_sys);
		chk(prot.loss_trip, 32'h0);
		bus(1'b1, ADR_PROT, 32'h0000_0011);
		bus(1'b1, ADR_LOSS, 32'h0003_0000);
		// zero feedback is the worst case for a zero threshold
		want.fb <= 16'h0000;
		repeat (60) @(posedge clk_sys);
		chk(prot.loss_trip, 32'h0);
		// pre-alarm above 120 % after 2 ticks
		bus(1'b1, ADR_OVLD, 32'h0064_0278);
		want.i_out <= 16'h04B1;
		repeat (8) @(posedge clk_sys);
		chk(prot.prealarm, 32'h0);
		repeat (30) @(posedge clk_sys);
		chk(prot.prealarm, 32'h1);
		want.i_out <= 16'h04B0;
		repeat (3) @(posedge clk_sys);
		chk(prot.prealarm, 32'h0);
		// limiting at 160 % in every run phase, constant coef 5
		bus(1'b1, ADR_CLIM, 32'h0105_0AA0);
		want.i_out <= 16'h0640;
		for (int r = 0; r < 4; r++)
		begin
			want.run <= dps_run_t'(r);
			repeat (3) @(posedge clk_sys);
			chk(prot.pbp_limit_en, r == 1 || r == 2);
			chk(prot.acc_supp_gain, r == 1 ? 10 : 0);
			chk(prot.const_supp_gain, r == 3 ? 5 : 0);
			chk(prot.climit_active, 32'h1);
		end
		want.i_out <= 16'h063F;
		want.run <= RUN_DEC;
		vb(10'd375);
		chk(prot.climit_active, 32'h0);
		chk(prot.ov_stall, 32'h1);
		chk(prot.decel_vlim_act, 32'h1);
		chk(prot.decel_vlim_factor, 32'h1);
		vb(10'd374);
		chk(prot.ov_stall, 32'h0);
		vb(10'd179);
		chk(prot.undervolt, 32'h1);
		chk(prot.dip_active, 32'h0);
		bus(1'b1, ADR_DIP, 32'h00FA_0001);
		// the action output follows the new setting a cycle later
		repeat (2) @(posedge clk_sys);
		chk(prot.dip_active, 32'h1);
		vb(10'd250);
		chk(prot.dip_active, 32'h0);
		chk(prot.undervolt, 32'h0);
		// oscillation band and jog priority
		bus(1'b1, ADR_PROT, 32'h0000_1011);
		want.freq <= 12'h064;
		want.jog_req <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(prot.osc_active, 32'h1);
		chk(prot.pwm_five_seg, 32'h1);
		chk(prot.osc_coef, 32'd30);
		chk(prot.amp_coef, 32'd5);
		chk(prot.jog_grant, 32'h0);
		bus(1'b1, ADR_OSC, 32'h0000_751E);
		want.freq <= 12'h1C3;
		repeat (3) @(posedge clk_sys);
		chk(prot.jog_grant, 32'h1);
		chk(prot.osc_active, 32'h0);
		// upper limit above the maximum frequency voids the band
		bus(1'b1, ADR_BAND, 32'h01F5_0032);
		want.freq <= 12'h064;
		repeat (3) @(posedge clk_sys);
		chk(prot.osc_active, 32'h0);
		chk(prot.osc_coef, 32'h0);
		// imbalance 2.5 against 2.00 must last beyond 6 s
		want.i_a <= 16'd500;
		want.i_b <= 16'd200;
		want.i_c <= 16'd200;
		repeat (598) @(posedge clk_sys);
		chk(prot.output_imbalance_fault, 32'h0);
		repeat (102) @(posedge clk_sys);
		chk(prot.output_imbalance_fault, 32'h1);
		bus(1'b0, ADR_STAT, 32'h0);
		chk(q[1], 32'h1);
		bus(1'b1, ADR_IMB, 32'h0);
		bus(1'b1, ADR_STAT, 32'h2);
		repeat (700) @(posedge clk_sys);
		chk(prot.output_imbalance_fault, 32'h0);
		results();
	end
endmodule
